/* File: nfc_pkg.sv */
// Package of pin-cycle timing, command codes and bus widths for the flash host controller
`default_nettype none
package nfc_pkg;
    // ---------------------------------------------------------------
    // Clock and timing
    // ---------------------------------------------------------------
    localparam int ClkPeriodNs = 100;
    localparam int PorWaitUs = 1000;
    localparam int PorWaitCycles = (PorWaitUs * 1000) / ClkPeriodNs;
    localparam int StrobeLowNs = 100;
    localparam int StrobeLowCycles = (StrobeLowNs + ClkPeriodNs - 1) / ClkPeriodNs;
    localparam int PhaseW = 2;
    localparam logic [PhaseW-1:0] PhaseLast = 2'h3;
    // ---------------------------------------------------------------
    // Bus widths
    // ---------------------------------------------------------------
    localparam int DataW = 16;
    localparam logic [7:0] UpperZero = 8'h00;
    // ---------------------------------------------------------------
    // Command codes
    // ---------------------------------------------------------------
    localparam logic [7:0] CmdReset = 8'hff;
    localparam logic [7:0] CmdStatus = 8'h70;
    localparam logic [7:0] CmdStatusEnh = 8'h78;
    localparam logic [7:0] CmdReadA = 8'h00;
    localparam logic [7:0] CmdReadB = 8'h30;
    localparam logic [7:0] CmdProgA = 8'h80;
    localparam logic [7:0] CmdProgB = 8'h10;
    localparam logic [7:0] CmdProgPlane = 8'h11;
    localparam logic [7:0] CmdProgCache = 8'h15;
    localparam logic [7:0] CmdEraseA = 8'h60;
    localparam logic [7:0] CmdEraseB = 8'hd0;
    localparam logic [7:0] CmdErasePlane = 8'hd1;
    localparam logic [7:0] CmdRandIn = 8'h85;
    localparam logic [7:0] CmdRandOutA = 8'h05;
    localparam logic [7:0] CmdRandOutB = 8'he0;
    localparam logic [7:0] CmdIdRead = 8'h90;
    localparam logic [7:0] CmdUidRead = 8'hed;
    localparam logic [7:0] CmdParamRead = 8'hec;
    localparam logic [7:0] CmdSetFeat = 8'hef;
    localparam logic [7:0] CmdGetFeat = 8'hee;
    localparam logic [7:0] CmdUnprotLo = 8'h23;
    localparam logic [7:0] CmdUnprotHi = 8'h24;
    localparam logic [7:0] CmdProtect = 8'h2a;
    localparam logic [7:0] CmdSolidProt = 8'h2c;
    localparam logic [7:0] CmdProtStatus = 8'h7a;
    localparam logic [7:0] CmdCacheSeq = 8'h31;
    localparam logic [7:0] CmdCacheEnd = 8'h3f;
    // ---------------------------------------------------------------
    // Bad-block marking
    // ---------------------------------------------------------------
    localparam logic [15:0] ErasedWord = 16'hffff;
    localparam logic [15:0] BadMarkWord = 16'h0000;
    // ---------------------------------------------------------------
    // Cycle kinds requested by the user side
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {KindCmd, KindAddr, KindDin, KindDout} nfc_kind_t;
endpackage
`default_nettype wire

/* File: nfc_host.sv */
// Host controller that drives the flash bus pins one cycle per request
`default_nettype none

// Behaviour
// - Address cycle: CLE low, ALE high.
// - Host holds write-protect high for program/erase addresses.
// - Command cycle: CLE high, ALE low.
// - Host holds write-protect high for program/erase commands.
// - Data in by write strobe, out by read.
// - Two-plane program 80,11,80,10 or 15 ending.
// - Two-plane erase 60,D1,60,D0 with addresses.
// - Host zeroes upper data lines on commands.
// - While busy only FFH, 70H, 78H issued.
// - Host waits ready or 1 ms after power-on.
// - Host holds write-protect low during power-up.
// - Host reads bad-block marks before erasing; the host does not check them, marks are read by the user with page reads.
module nfc_host #(
    parameter int PorCycles = nfc_pkg::PorWaitCycles
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // User request side
    input wire logic reqValid,
    output logic reqReady,
    input wire nfc_pkg::nfc_kind_t reqKind,
    input wire logic [nfc_pkg::DataW-1:0] reqData,
    input wire logic writeEnable,
    output logic rspValid,
    output logic [nfc_pkg::DataW-1:0] rspData,
    output logic rejected,
    output logic busy,
    output logic powerUpDone,
    // Flash pins
    output logic chipSelN,
    output logic cmdLatch,
    output logic addrLatch,
    output logic wrStrobeN,
    output logic rd_strobe_n,
    output logic wrProtN,
    input wire logic readyBusyN,
    input wire logic [nfc_pkg::DataW-1:0] ioIn,
    output logic [nfc_pkg::DataW-1:0] ioOut,
    output logic ioOeN
);
    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {StPor, StIdle, StCycle} nfc_state_t;
    nfc_state_t state_q, state_d;
    logic [31:0] porCnt_q;                     // Power-on wait counter
    logic [nfc_pkg::PhaseW-1:0] phase_q;       // Phase within a bus cycle
    nfc_pkg::nfc_kind_t kind_q;                // Kind of cycle in flight
    logic [nfc_pkg::DataW-1:0] out_q;          // Value driven on the bus
    logic [nfc_pkg::DataW-1:0] rsp_q;          // Captured read value
    logic rspValid_q;
    logic rej_q;
    logic wp_q;                                // Registered write-protect level

    // ---------------------------------------------------------------
    // Decode
    // ---------------------------------------------------------------
    wire logic devBusy = ~readyBusyN;
    wire logic [7:0] cmdCode = reqData[7:0];
    wire logic busyOk = (cmdCode == nfc_pkg::CmdReset) || (cmdCode == nfc_pkg::CmdStatus)
        || (cmdCode == nfc_pkg::CmdStatusEnh);
    wire logic legalNow = !devBusy || ((reqKind == nfc_pkg::KindCmd) && busyOk);
    wire logic idle = (state_q == StIdle);
    wire logic take = idle && reqValid && legalNow;
    // Illegal-while-busy requests are refused, not stalled, so the user sees it
    wire logic refuse = idle && reqValid && !legalNow;
    wire logic cycEnd = (state_q == StCycle) && (phase_q == nfc_pkg::PhaseLast);
    wire logic strobeLow = (state_q == StCycle) && (phase_q != nfc_pkg::PhaseLast)
        && (phase_q != '0);

    assign reqReady = idle && legalNow;
    assign rspValid = rspValid_q;
    assign rspData = rsp_q;
    assign rejected = rej_q;
    assign busy = devBusy;
    assign powerUpDone = (state_q != StPor);
    assign chipSelN = !(state_q == StCycle);
    assign cmdLatch = (state_q == StCycle) && (kind_q == nfc_pkg::KindCmd);
    assign addrLatch = (state_q == StCycle) && (kind_q == nfc_pkg::KindAddr);
    // write strobe rises at end of low phase
    assign wrStrobeN = !(strobeLow && (kind_q != nfc_pkg::KindDout));
    // read strobe only for data out
    assign rd_strobe_n = !(strobeLow && (kind_q == nfc_pkg::KindDout));
    assign ioOut = out_q;
    assign ioOeN = !((state_q == StCycle) && (kind_q != nfc_pkg::KindDout));
    assign wrProtN = wp_q;

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            // wait the full power-on time or see ready
            StPor: if (porCnt_q >= 32'(PorCycles) - 32'h1 || (readyBusyN && porCnt_q > 0)) begin
                state_d = StIdle;
            end
            StIdle: if (take) begin
                state_d = StCycle;
            end
            StCycle: if (cycEnd) begin
                state_d = StIdle;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= StPor;
        end else begin
            state_q <= state_d;
        end
    end

    // Power-on counter and bus phase
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            porCnt_q <= '0;
            phase_q <= '0;
        end else begin
            porCnt_q <= (state_q == StPor) ? porCnt_q + 32'h1 : porCnt_q;
            phase_q <= (state_q == StCycle) ? phase_q + 2'h1 : '0;
        end
    end

    // Request capture; upper lines forced to zero on commands
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            kind_q <= nfc_pkg::KindCmd;
            out_q <= '0;
        end else if (take) begin
            kind_q <= reqKind;
            // upper data lines zero for commands
            out_q <= (reqKind == nfc_pkg::KindCmd) ? {nfc_pkg::UpperZero, cmdCode} : reqData;
        end
    end

    // Write-protect, read capture and refusal pulse
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wp_q <= 1'b0;
            rsp_q <= '0;
            rspValid_q <= 1'b0;
            rej_q <= 1'b0;
        end else begin
            wp_q <= (state_q != StPor) && writeEnable;
            rspValid_q <= 1'b0;
            rej_q <= refuse;
            // marker words returned to user
            // Sample just before the read strobe rises
            if ((state_q == StCycle) && (kind_q == nfc_pkg::KindDout)
                    && (phase_q == nfc_pkg::PhaseLast - 2'h1)) begin
                rsp_q <= ioIn;
                rspValid_q <= 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    // A refused request must start no bus cycle and must be flagged to the user
    busy_filter_a: assert property (@(posedge clk) disable iff (!resetn)
        (idle && reqValid && devBusy && !((reqKind == nfc_pkg::KindCmd) && busyOk))
        |=> (chipSelN && rejected))
        else $error("request not refused while busy");
    cmd_upper_a: assert property (@(posedge clk) disable iff (!resetn)
        cmdLatch |-> (ioOut[15:8] == nfc_pkg::UpperZero))
        else $error("upper lines not zero in command cycle");
    latch_excl_a: assert property (@(posedge clk) disable iff (!resetn)
        !(cmdLatch && addrLatch))
        else $error("both latches high");
    addr_cycle_a: assert property (@(posedge clk) disable iff (!resetn)
        addrLatch |-> (!chipSelN && rd_strobe_n))
        else $error("address cycle pin levels wrong");
    data_dir_a: assert property (@(posedge clk) disable iff (!resetn)
        !rd_strobe_n |-> (wrStrobeN && ioOeN && !cmdLatch && !addrLatch))
        else $error("read strobe with wrong pins");
    strobe_rise_a: assert property (@(posedge clk) disable iff (!resetn)
        ($rose(wrStrobeN) && !chipSelN) |-> $stable(ioOut))
        else $error("data moved at write strobe rise");
    por_hold_a: assert property (@(posedge clk) disable iff (!resetn)
        (state_q == StPor) |-> ##1 !wrProtN)
        else $error("write-protect released during power-up");
    por_quiet_a: assert property (@(posedge clk) disable iff (!resetn)
        (state_q == StPor) |-> chipSelN)
        else $error("bus used before power-up done");
    ready_gate_a: assert property (@(posedge clk) disable iff (!resetn)
        !powerUpDone |-> !reqReady)
        else $error("request accepted before power-up done");
    cycle_len_a: assert property (@(posedge clk) disable iff (!resetn)
        $fell(chipSelN) |-> !chipSelN [*4] ##1 chipSelN)
        else $error("chip select not low for one full cycle");
    rsp_dout_a: assert property (@(posedge clk) disable iff (!resetn)
        rspValid |-> (kind_q == nfc_pkg::KindDout))
        else $error("read data flagged outside a data-out cycle");
endmodule
`default_nettype wire

/* File: nfc_flash_model.sv */
// Behavioural flash device that answers the host controller's pins
`default_nettype none
module nfc_flash_model #(
    parameter int PorBusy = 8,
    parameter int OpBusy = 30,
    parameter logic [15:0] BadAddr = 16'h0bad
) (
    // Host pins
    input wire logic clk,
    input wire logic chipSelN,
    input wire logic cmdLatch,
    input wire logic addrLatch,
    input wire logic wrStrobeN,
    input wire logic rdStrobeN,
    input wire logic wrProtN,
    input wire logic [15:0] ioOut,
    // Device drive
    output logic readyBusyN,
    output logic [15:0] ioIn
);
    timeunit 1ns;
    timeprecision 1ns;
    int busyCnt = PorBusy; // Power-on reset runs from time zero
    logic porQ = 1'b1, progQ = 1'b0, readQ = 1'b0, wsPrev = 1'b1;
    logic [7:0] lastCmd = 8'h00;
    logic [15:0] lastAddr = 16'h0000, lastOut = 16'h0000, word;
    wire logic wrRise = wrStrobeN && !wsPrev && !chipSelN && rdStrobeN;
    wire logic isCmd = wrRise && cmdLatch && !addrLatch;
    wire logic isAddr = wrRise && !cmdLatch && addrLatch;
    wire logic [7:0] code = ioOut[7:0];
    wire logic known = code inside {8'h00, 8'h30, 8'h85, 8'h05, 8'he0, 8'h31, 8'h3f,
        8'h90, 8'hec, 8'hed, 8'hef, 8'hee, 8'hff, 8'h80, 8'h10, 8'h15, 8'h60, 8'hd0,
        8'h23, 8'h24, 8'h2a, 8'h2c, 8'h70, 8'h78, 8'h7a, 8'h11, 8'hd1};
    wire logic okBusy = !porQ && (code == 8'hff || code == 8'h70 || code == 8'h78);
    wire logic take = isCmd && known && (busyCnt == 0 || okBusy);
    wire logic startOp = code inside {8'h30, 8'h10, 8'h15, 8'hd0};
    assign word = readQ ? ((lastAddr == BadAddr) ? 16'h0000 : 16'hffff) : {8'h00, lastCmd};
    // drive only in a data-out strobe; otherwise a changed value, not the last
    assign ioIn = (!chipSelN && !rdStrobeN && !cmdLatch && !addrLatch) ? word : ~lastOut;
    assign readyBusyN = (busyCnt == 0);
    always @(negedge rdStrobeN) lastOut <= word;
    // Decode one clock after the strobe rises, data is still held then
    always @(posedge clk) begin
        wsPrev <= wrStrobeN;
        if (busyCnt == 0) porQ <= 1'b0;
        if (isAddr && busyCnt == 0) lastAddr <= ioOut;
        if (take) begin
            lastCmd <= code;
            readQ <= (code == 8'h30);
            if (startOp) begin
                busyCnt <= OpBusy;
                progQ <= (code != 8'h30);
            end
        end else if (busyCnt > 0) begin
            // write-protect low aborts program or erase
            busyCnt <= (!wrProtN && progQ) ? 0 : busyCnt - 1;
        end
    end
endmodule
`default_nettype wire

/* File: tb_nfc_host.sv */
// Bench: host controller driving a behavioural flash device
`default_nettype none
module tb_nfc_host;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PorSim = 20; // Short power-on wait keeps the run brief
    logic clk = 1'b0, resetn = 1'b0, reqValid = 1'b0, writeEnable = 1'b0;
    nfc_pkg::nfc_kind_t reqKind = nfc_pkg::KindCmd;
    logic [15:0] reqData = 16'h0000, got, pins, rspData, ioIn, ioOut;
    logic reqReady, rspValid, rejected, busy, powerUpDone, chipSelN, cmdLatch;
    logic addrLatch, wrStrobeN, rdStrobeN, wrProtN, readyBusyN, ioOeN;
    int errorCnt = 0, samplesChecked = 0, cycles = 0;
    nfc_host #(.PorCycles(PorSim)) DUT (.clk(clk), .resetn(resetn), .reqValid(reqValid),
        .reqReady(reqReady), .reqKind(reqKind), .reqData(reqData), .writeEnable(writeEnable),
        .rspValid(rspValid), .rspData(rspData), .rejected(rejected), .busy(busy),
        .powerUpDone(powerUpDone), .chipSelN(chipSelN), .cmdLatch(cmdLatch),
        .addrLatch(addrLatch), .wrStrobeN(wrStrobeN), .rd_strobe_n(rdStrobeN),
        .wrProtN(wrProtN), .readyBusyN(readyBusyN), .ioIn(ioIn), .ioOut(ioOut), .ioOeN(ioOeN));
    nfc_flash_model flash (.clk(clk), .chipSelN(chipSelN), .cmdLatch(cmdLatch),
        .addrLatch(addrLatch), .wrStrobeN(wrStrobeN), .rdStrobeN(rdStrobeN),
        .wrProtN(wrProtN), .ioOut(ioOut), .readyBusyN(readyBusyN), .ioIn(ioIn));
    always #50 clk = ~clk;
    // Hang guard: the whole run needs well under this many cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            errorCnt++;
            endSim();
        end
    end
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            errorCnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic endSim();
        if (errorCnt == 0 && samplesChecked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // One bus cycle; pins are snapshot while selected, read data caught on its pulse
    task automatic send(input nfc_pkg::nfc_kind_t k, input logic [15:0] d);
        reqKind <= k;
        reqData <= d;
        reqValid <= 1'b1;
        do @(negedge clk); while (reqReady !== 1'b1);
        @(posedge clk);
        reqValid <= 1'b0;
        repeat (5) begin
            @(negedge clk);
            if (chipSelN === 1'b0) pins = {3'h0, chipSelN, cmdLatch, addrLatch, wrProtN, ioOeN,
                ioOut[15:8]};
            if (rspValid === 1'b1) got = rspData;
        end
        @(posedge clk);
    endtask
    task automatic cmd(input logic [7:0] c);
        send(nfc_pkg::KindCmd, {8'h00, c});
    endtask
    task automatic waitReady();
        repeat (60) if (busy === 1'b1) @(negedge clk);
        chk("ready", {15'h0, busy}, 16'h0000);
        @(posedge clk);
    endtask
    // Page read of one address, compare the first word
    task automatic readAt(input logic [15:0] a, input logic [15:0] exp);
        cmd(8'h00);
        send(nfc_pkg::KindAddr, a);
        cmd(8'h30);
        waitReady();
        send(nfc_pkg::KindDout, 16'h0000);
        chk("readWord", got, exp);
    endtask
    task automatic tPower();
        int n = 0;
        chk("wpReset", {15'h0, wrProtN}, 16'h0000);
        resetn <= 1'b1;
        while (powerUpDone !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        chk("porByReady", {15'h0, n < PorSim}, 16'h0001);
        @(posedge clk);
    endtask
    // Request the busy filter must refuse: no bus cycle, a rejected pulse
    task automatic refuse(input nfc_pkg::nfc_kind_t k, input logic [15:0] d);
        reqKind <= k;
        reqData <= d;
        reqValid <= 1'b1;
        @(negedge clk);
        chk("readyBusy", {15'h0, reqReady}, 16'h0000);
        @(negedge clk);
        chk("rejected", {15'h0, rejected}, 16'h0001);
        chk("noCycle", {15'h0, chipSelN}, 16'h0001);
        @(posedge clk);
        reqValid <= 1'b0;
        @(posedge clk);
    endtask
    // Pins for command, address and data-out cycles, busy filter, status during busy, bad mark
    task automatic tRead();
        cmd(8'h00);
        chk("cmdPins", pins, 16'h0800);
        send(nfc_pkg::KindAddr, 16'h0123);
        chk("addrPins", pins, 16'h0401);
        cmd(8'h30);
        chk("busyRead", {15'h0, busy}, 16'h0001);
        refuse(nfc_pkg::KindCmd, 16'h0005);
        refuse(nfc_pkg::KindDin, 16'h0005);
        chk("refuseSent", {15'h0, busy}, 16'h0001);
        cmd(8'h70);
        waitReady();
        send(nfc_pkg::KindDout, 16'h0000);
        chk("statusTaken", got, 16'h0070);
        chk("doutPins", pins & 16'hff00, 16'h0100);
        readAt(16'h0bad, 16'h0000);
        readAt(16'h0001, 16'hffff);
    endtask
    // Single-cycle codes land; an undefined one leaves the last in place
    task automatic tCodes();
        logic [7:0] codes [11] = '{8'h90, 8'hec, 8'hed, 8'hef, 8'hee, 8'h23, 8'h24, 8'h2a,
            8'h2c, 8'h7a, 8'h85};
        foreach (codes[i]) begin
            cmd(codes[i]);
            send(nfc_pkg::KindDout, 16'h0000);
            chk("codeTaken", got, {8'h00, codes[i]});
        end
        cmd(8'h5a);
        send(nfc_pkg::KindDout, 16'h0000);
        chk("codeIgnored", got, 16'h0085);
    endtask
    // Two-plane erase and cache program, then abort by write-protect
    task automatic tWrite();
        writeEnable <= 1'b1;
        cmd(8'h60);
        send(nfc_pkg::KindAddr, 16'h0040);
        cmd(8'hd1);
        chk("wpCmdPins", pins, 16'h0a00);
        cmd(8'h60);
        send(nfc_pkg::KindAddr, 16'h0080);
        cmd(8'hd0);
        chk("eraseBusy", {15'h0, busy}, 16'h0001);
        waitReady();
        cmd(8'h80);
        send(nfc_pkg::KindAddr, 16'h0000);
        send(nfc_pkg::KindDin, 16'h5aa5);
        chk("dinPins", pins, 16'h025a);
        cmd(8'h11);
        cmd(8'h80);
        send(nfc_pkg::KindAddr, 16'h0040);
        send(nfc_pkg::KindDin, 16'h1234);
        cmd(8'h15);
        chk("progBusy", {15'h0, busy}, 16'h0001);
        writeEnable <= 1'b0;
        repeat (4) @(negedge clk);
        chk("wpAbort", {15'h0, busy}, 16'h0000);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        tPower();
        tRead();
        tCodes();
        tWrite();
        endSim();
    end
endmodule
`default_nettype wire
